// ===== rtl/thermal_standby_fault.sv
// Purpose: standby control, conversion sequencing and sensor fault handling
// Assumes: converter and serial interface sit outside on the same clock
// Notes: one-cycle read latency; status flags clear on status read
//
// How it works
// - pin low or config bit enters standby
// - free-run only when pin high, bit clear
// - standby aborts conversion, no value written
// - register port keeps working in standby
// - hardware standby blocks even one-shot
// - one-shot write in software standby converts both channels once
// - sample open comparator at conversion start
// - underrange remote result reports minus 128
// - alert low on limit breach or open
`timescale 1ns/1ps
`include "thermal_params.svh"

module thermal_standby_fault
	import thermal_pkg::*;
#(
	parameter int GAP_CYCLES = `CONV_GAP_CYCLES
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// register port
	input wire reg_write_t reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_read_addr_in,
	output logic [7:0] reg_read_data_out,
	// pins from outside
	input wire logic low_power_request_n_in,
	input wire logic open_circuit_in,
	// converter
	input wire adc_result_t adc_in,
	output logic adc_start_out,
	output logic adc_abort_out,
	output logic adc_remote_out,
	// open-drain alert
	input wire logic alert_line_in,
	output logic alert_out,
	output logic alert_oe_n_out,
	// state view
	output logic standby_out
);

	// ==========================================================
	// declarations
	logic pin_level; // filtered standby pin
	logic open_level; // filtered open comparator
	logic hw_standby; // pin asks for standby
	logic sw_standby; // config bit asks for standby
	logic conv_enable; // free-running conversions allowed
	logic one_shot_hit; // accepted one-shot write
	logic keep_going; // a running conversion may go on
	logic local_store; // local result written this cycle
	logic remote_store; // remote result written this cycle
	logic [7:0] remote_code; // remote result after underrange fix
	conv_state_t state_reg, state_next;
	logic one_shot_reg, one_shot_next; // current run is a one-shot
	logic [`GAP_WIDTH-1:0] gap_reg, gap_next; // pause between rounds
	logic start_reg, start_next;
	logic abort_reg, abort_next;
	logic remote_sel_reg, remote_sel_next;
	logic [7:0] config_reg, config_next;
	logic [7:0] local_high_reg, local_high_next;
	logic [7:0] local_low_reg, local_low_next;
	logic [7:0] remote_high_reg, remote_high_next;
	logic [7:0] remote_low_reg, remote_low_next;
	logic [7:0] local_value_reg, local_value_next;
	logic [7:0] remote_value_reg, remote_value_next;
	logic [6:2] flags_reg, flags_next; // sticky status flags
	logic [6:2] flags_set; // events this cycle
	logic [7:0] read_data_reg, read_data_next;
	logic [7:0] read_mux;
	logic alert_reg, alert_next;
	logic standby_reg, standby_next;

	// ==========================================================
	// pin synchronisers
	level_sync #(.RESET_VALUE(1'b1)) sync_standby (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.level_in(low_power_request_n_in),
		.level_out(pin_level)
	);

	level_sync #(.RESET_VALUE(1'b0)) sync_open (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.level_in(open_circuit_in),
		.level_out(open_level)
	);

	// ==========================================================
	// standby decode
	always_comb begin
		hw_standby = !pin_level;
		sw_standby = config_reg[`CFG_STANDBY_BIT];
		conv_enable = !hw_standby && !sw_standby;
		one_shot_hit = reg_write_in.strobe && (reg_write_in.addr == `OFF_ONE_SHOT)
			&& !hw_standby && sw_standby;
		// running work stops in standby unless it is an allowed one-shot
		keep_going = conv_enable || (one_shot_reg && !hw_standby);
		local_store = (state_reg == ST_LOCAL) && adc_in.done && keep_going;
		remote_store = (state_reg == ST_REMOTE) && adc_in.done && keep_going;
		remote_code = adc_in.underrange ? `MIN_CODE : adc_in.code;
	end

	// ==========================================================
	// conversion sequencer next values
	always_comb begin
		state_next = state_reg;
		one_shot_next = one_shot_reg;
		gap_next = gap_reg;
		start_next = 1'b0;
		abort_next = 1'b0;
		remote_sel_next = remote_sel_reg;
		case (state_reg)
			// waiting for a reason to convert
			ST_IDLE: begin
				if (conv_enable) begin
					state_next = ST_LOCAL;
					start_next = 1'b1;
					remote_sel_next = 1'b0;
				end else if (one_shot_hit) begin
					state_next = ST_LOCAL;
					start_next = 1'b1;
					remote_sel_next = 1'b0;
					one_shot_next = 1'b1;
				end
			end
			// pause between rounds
			ST_GAP: begin
				if (!conv_enable || gap_reg == '0) begin
					state_next = ST_IDLE;
				end else begin
					gap_next = gap_reg - 1'b1;
				end
			end
			// converting one channel
			ST_LOCAL, ST_REMOTE: begin
				if (!keep_going) begin
					state_next = ST_IDLE;
					abort_next = 1'b1;
					one_shot_next = 1'b0;
				end else if (local_store) begin
					state_next = ST_REMOTE;
					start_next = 1'b1;
					remote_sel_next = 1'b1;
				end else if (remote_store && one_shot_reg) begin
					state_next = ST_IDLE;
					one_shot_next = 1'b0;
				end else if (remote_store) begin
					state_next = ST_GAP;
					gap_next = GAP_CYCLES[`GAP_WIDTH-1:0];
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// register file next values
	always_comb begin
		config_next = config_reg;
		local_high_next = local_high_reg;
		local_low_next = local_low_reg;
		remote_high_next = remote_high_reg;
		remote_low_next = remote_low_reg;
		if (reg_write_in.strobe) begin
			case (reg_write_in.addr)
				`OFF_CONFIG: config_next = reg_write_in.data;
				`OFF_LOCAL_HIGH: local_high_next = reg_write_in.data;
				`OFF_LOCAL_LOW: local_low_next = reg_write_in.data;
				`OFF_REMOTE_HIGH: remote_high_next = reg_write_in.data;
				`OFF_REMOTE_LOW: remote_low_next = reg_write_in.data;
				default: config_next = config_reg;
			endcase
		end
		local_value_next = local_store ? adc_in.code : local_value_reg;
		remote_value_next = remote_store ? remote_code : remote_value_reg;
		// open comparator sampled at each start
		flags_set = '0;
		flags_set[`STAT_OPEN_BIT] = start_next && open_level;
		// signed limit checks on stored results
		flags_set[`STAT_LOCAL_HIGH_BIT] = local_store
			&& ($signed(adc_in.code) > $signed(local_high_reg));
		flags_set[`STAT_LOCAL_LOW_BIT] = local_store
			&& ($signed(adc_in.code) < $signed(local_low_reg));
		flags_set[`STAT_REMOTE_HIGH_BIT] = remote_store
			&& ($signed(remote_code) > $signed(remote_high_reg));
		// a 0x80 low limit never trips on the minimum code
		flags_set[`STAT_REMOTE_LOW_BIT] = remote_store
			&& ($signed(remote_code) < $signed(remote_low_reg));
		// status read clears, a same-cycle event wins
		flags_next = flags_reg;
		if (reg_read_in && reg_read_addr_in == `OFF_STATUS) begin
			flags_next = '0;
		end
		flags_next = flags_next | flags_set;
		// read multiplexer
		case (reg_read_addr_in)
			`OFF_LOCAL_VALUE: read_mux = local_value_reg;
			`OFF_REMOTE_VALUE: read_mux = remote_value_reg;
			`OFF_STATUS: read_mux = {state_reg == ST_LOCAL || state_reg == ST_REMOTE,
				flags_reg, 2'b00};
			`OFF_CONFIG: read_mux = config_reg;
			`OFF_LOCAL_HIGH: read_mux = local_high_reg;
			`OFF_LOCAL_LOW: read_mux = local_low_reg;
			`OFF_REMOTE_HIGH: read_mux = remote_high_reg;
			`OFF_REMOTE_LOW: read_mux = remote_low_reg;
			default: read_mux = 8'h00;
		endcase
		read_data_next = reg_read_in ? read_mux : read_data_reg;
		alert_next = |flags_reg;
		standby_next = hw_standby || sw_standby;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_reg <= ST_IDLE;
			one_shot_reg <= 1'b0;
			gap_reg <= '0;
			start_reg <= 1'b0;
			abort_reg <= 1'b0;
			remote_sel_reg <= 1'b0;
			config_reg <= `RST_CONFIG;
			local_high_reg <= `RST_HIGH_LIMIT;
			local_low_reg <= `RST_LOW_LIMIT;
			remote_high_reg <= `RST_HIGH_LIMIT;
			remote_low_reg <= `RST_LOW_LIMIT;
			local_value_reg <= `RST_VALUE;
			remote_value_reg <= `RST_VALUE;
			flags_reg <= '0;
			read_data_reg <= 8'h00;
			alert_reg <= 1'b0;
			standby_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			one_shot_reg <= one_shot_next;
			gap_reg <= gap_next;
			start_reg <= start_next;
			abort_reg <= abort_next;
			remote_sel_reg <= remote_sel_next;
			config_reg <= config_next;
			local_high_reg <= local_high_next;
			local_low_reg <= local_low_next;
			remote_high_reg <= remote_high_next;
			remote_low_reg <= remote_low_next;
			local_value_reg <= local_value_next;
			remote_value_reg <= remote_value_next;
			flags_reg <= flags_next;
			read_data_reg <= read_data_next;
			alert_reg <= alert_next;
			standby_reg <= standby_next;
		end
	end

	// outputs from flops, alert_oe_n_out inverted, alert_out tied low; alert_line_in is the wire level, for the bench
	assign reg_read_data_out = read_data_reg;
	assign adc_start_out = start_reg;
	assign adc_abort_out = abort_reg;
	assign adc_remote_out = remote_sel_reg;
	assign alert_out = 1'b0 & alert_reg & alert_line_in;
	assign alert_oe_n_out = !alert_reg;
	assign standby_out = standby_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	sequence s_shot_done;
		one_shot_reg && remote_store;
	endsequence

	AST_STANDBY_ENTER: assert property (hw_standby || sw_standby |=> standby_out)
		else $error("standby request not shown");
	AST_START_ONLY_NORMAL: assert property (adc_start_out && !one_shot_reg |-> $past(conv_enable))
		else $error("conversion started outside normal mode");
	AST_ABORT_NO_STORE: assert property ((state_reg == ST_LOCAL || state_reg == ST_REMOTE)
		&& hw_standby |=> adc_abort_out && state_reg == ST_IDLE
		&& $stable(local_value_reg) && $stable(remote_value_reg))
		else $error("standby did not abort cleanly");
	AST_WRITE_IN_STANDBY: assert property (reg_write_in.strobe
		&& reg_write_in.addr == `OFF_CONFIG |=> config_reg == $past(reg_write_in.data))
		else $error("config write lost");
	AST_HW_BLOCKS_ALL: assert property (hw_standby ##1 hw_standby |=> !adc_start_out)
		else $error("start during hardware standby");
	AST_ONE_SHOT_START: assert property (one_shot_hit && state_reg == ST_IDLE
		|=> adc_start_out && one_shot_reg && !adc_remote_out)
		else $error("one-shot did not start");
	AST_OPEN_SAMPLED: assert property (adc_start_out && $past(open_level)
		|-> flags_reg[`STAT_OPEN_BIT])
		else $error("open fault not flagged");
	AST_MIN_CODE: assert property (remote_store && adc_in.underrange
		|=> remote_value_reg == `MIN_CODE)
		else $error("underrange not reported as minimum");
	AST_ALERT_LOW: assert property (|flags_reg |=> !alert_oe_n_out ##1 !alert_oe_n_out
		|| !(|$past(flags_reg)))
		else $error("alert not driven");
	AST_SHOT_IDLE: assert property (s_shot_done |=> state_reg == ST_IDLE && !one_shot_reg
		&& remote_value_reg == $past(remote_code))
		else $error("one-shot did not finish in idle");

endmodule // thermal_standby_fault

// ===== common/thermal_params.svh
// Purpose: offsets, field positions, reset values and counts of the standby/fault block
// Assumes: byte-wide registers reached through the device register port
// Notes: definitions only
`ifndef THERMAL_PARAMS_SVH
`define THERMAL_PARAMS_SVH

// ==========================================================
// register offsets
`define OFF_LOCAL_VALUE 8'h00
`define OFF_REMOTE_VALUE 8'h01
`define OFF_STATUS 8'h02
`define OFF_CONFIG 8'h03
`define OFF_LOCAL_HIGH 8'h05
`define OFF_LOCAL_LOW 8'h06
`define OFF_REMOTE_HIGH 8'h07
`define OFF_REMOTE_LOW 8'h08
`define OFF_ONE_SHOT 8'h0F

// ==========================================================
// field positions
`define CFG_STANDBY_BIT 6
`define STAT_BUSY_BIT 7
`define STAT_LOCAL_HIGH_BIT 6
`define STAT_LOCAL_LOW_BIT 5
`define STAT_REMOTE_HIGH_BIT 4
`define STAT_REMOTE_LOW_BIT 3
`define STAT_OPEN_BIT 2

// ==========================================================
// reset values and codes
`define RST_CONFIG 8'h00
`define RST_HIGH_LIMIT 8'h7F
`define RST_LOW_LIMIT 8'h00
`define RST_VALUE 8'h00
`define MIN_CODE 8'h80

// ==========================================================
// timing counts
`define CONV_GAP_CYCLES 16
`define GAP_WIDTH 16

`endif

// ===== common/thermal_pkg.sv
// Purpose: types shared by the standby/fault block
// Assumes: thermal_params.svh holds the numbers
// Notes: types only
package thermal_pkg;

	// ==========================================================
	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_GAP,
		ST_LOCAL,
		ST_REMOTE
	} conv_state_t;

	// register write from the serial interface
	typedef struct packed {
		logic strobe;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_write_t;

	// result handed back by the converter
	typedef struct packed {
		logic done;
		logic underrange;
		logic [7:0] code;
	} adc_result_t;

endpackage

// ===== rtl/level_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clock_in
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps

module level_sync #(
	parameter logic RESET_VALUE = 1'b1
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// async level and filtered result
	input wire logic level_in,
	output logic level_out
);

	logic [2:0] stage_reg; // stage_reg[0] feeds only stage_reg[1]
	logic [2:0] stage_next;
	logic level_reg;
	logic level_next;

	// ==========================================================
	// next values
	always_comb begin
		stage_next = {stage_reg[1:0], level_in};
		level_next = level_reg;
		// take the level once the two late stages agree
		if (stage_reg[1] == stage_reg[2]) begin
			level_next = stage_reg[2];
		end
	end

	// registers
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			stage_reg <= {3{RESET_VALUE}};
			level_reg <= RESET_VALUE;
		end else begin
			stage_reg <= stage_next;
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;

endmodule // level_sync

// ===== testbench/converter_model.sv
// Purpose: behavioural converter answering start pulses after a fixed latency
// Assumes: same clock as the block, one conversion at a time
// Notes: code bus shows a changing pattern outside the done cycle
`timescale 1ns/1ps

module converter_model
	import thermal_pkg::*;
#(
	parameter int LATENCY = 5
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// control from the block
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic remote_in,
	// results chosen by the bench
	input wire logic [7:0] local_code_in,
	input wire logic [7:0] remote_code_in,
	input wire logic underrange_in,
	// result to the block
	output adc_result_t adc_out
);
	// ==========================================================
	// conversion timer
	int count; // cycles left, 0 when idle
	logic chan; // channel being converted
	logic [7:0] noise = 8'h00; // filler pattern outside done, known from the start
	// counts down and reports; an abort drops the conversion silently
	always @(posedge clock_in) begin
		noise <= noise + 8'h3B;
		adc_out <= '{1'b0, noise[0], noise};
		if (reset_in || abort_in) begin
			count <= 0;
		end else if (start_in) begin
			count <= LATENCY;
			chan <= remote_in;
		end else if (count == 1) begin
			count <= 0;
			adc_out <= '{1'b1, chan & underrange_in, chan ? remote_code_in : local_code_in};
		end else if (count > 1) begin
			count <= count - 1;
		end
	end
endmodule // converter_model

// ===== testbench/thermal_standby_fault_tb.sv
// Purpose: self-checking bench for standby, one-shot and sensor fault handling
// Assumes: design uses a short gap parameter
// Notes: register access through the block's byte port
`timescale 1ns/1ps
`include "thermal_params.svh"

module thermal_standby_fault_tb;
	import thermal_pkg::*;
	// ==========================================================
	// signals
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	reg_write_t reg_write_in = '0;
	logic reg_read_in = 1'b0;
	logic [7:0] reg_read_addr_in = 8'h00;
	logic [7:0] reg_read_data_out;
	logic low_power_request_n_in = 1'b1;
	logic open_circuit_in = 1'b0;
	adc_result_t adc_in;
	logic adc_start_out, adc_abort_out, adc_remote_out;
	logic alert_out, alert_oe_n_out, standby_out;
	logic alert_line; // wired alert with pull-up
	logic [7:0] local_code = 8'h19;
	logic [7:0] remote_code = 8'h2A;
	logic underrange = 1'b0;
	logic [7:0] d;
	int failures = 0;
	int compares = 0;
	int starts = 0;
	int aborts = 0;

	assign alert_line = alert_oe_n_out ? 1'b1 : alert_out;
	always #5 clock_in = ~clock_in;
	// count converter control pulses
	always @(posedge clock_in) begin
		if (adc_start_out === 1'b1) starts <= starts + 1;
		if (adc_abort_out === 1'b1) aborts <= aborts + 1;
	end

	// ==========================================================
	// instances
	thermal_standby_fault #(.GAP_CYCLES(2)) i_thermal_standby_fault (
		.clock_in(clock_in), .reset_in(reset_in),
		.reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_read_addr_in(reg_read_addr_in), .reg_read_data_out(reg_read_data_out),
		.low_power_request_n_in(low_power_request_n_in), .open_circuit_in(open_circuit_in),
		.adc_in(adc_in), .adc_start_out(adc_start_out), .adc_abort_out(adc_abort_out),
		.adc_remote_out(adc_remote_out), .alert_line_in(alert_line),
		.alert_out(alert_out), .alert_oe_n_out(alert_oe_n_out), .standby_out(standby_out)
	);
	converter_model #(.LATENCY(5)) i_converter_model (
		.clock_in(clock_in), .reset_in(reset_in),
		.start_in(adc_start_out), .abort_in(adc_abort_out), .remote_in(adc_remote_out),
		.local_code_in(local_code), .remote_code_in(remote_code),
		.underrange_in(underrange), .adc_out(adc_in)
	);

	// ==========================================================
	// tasks
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock_in);
		reg_write_in <= '{1'b1, a, v};
		@(posedge clock_in);
		reg_write_in.strobe <= 1'b0;
	endtask
	// one-cycle read pulse, data taken a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock_in);
		reg_read_in <= 1'b1;
		reg_read_addr_in <= a;
		@(posedge clock_in);
		reg_read_in <= 1'b0;
		@(posedge clock_in);
		#1 v = reg_read_data_out;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog far beyond the planned few hundred cycles
	initial begin
		repeat (20000) @(posedge clock_in);
		failures++;
		give_verdict();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (10) @(posedge clock_in);
		reset_in <= 1'b0;
		// normal conversions fill both value registers
		cycles(60);
		rd(`OFF_LOCAL_VALUE, d); check("local", d, 8'h19);
		rd(`OFF_REMOTE_VALUE, d); check("remote", d, 8'h2A);
		rd(`OFF_STATUS, d); check("status", d & 8'h7C, 8'h00);
		check("alert", {7'h00, alert_oe_n_out}, 8'h01);
		$display("test normal done");
		// software standby entered mid-conversion
		// look a step after the edge so the start pulse has settled
		do cycles(1); while (adc_start_out !== 1'b1);
		local_code <= 8'h33;
		remote_code <= 8'h44;
		aborts = 0;
		wr(`OFF_CONFIG, 8'h40);
		cycles(30);
		check("standby", {7'h00, standby_out}, 8'h01);
		check("aborts", aborts[7:0], 8'h01);
		rd(`OFF_LOCAL_VALUE, d); check("local", d, 8'h19);
		rd(`OFF_REMOTE_VALUE, d); check("remote", d, 8'h2A);
		rd(`OFF_CONFIG, d); check("config", d, 8'h40);
		wr(`OFF_REMOTE_HIGH, 8'h70);
		rd(`OFF_REMOTE_HIGH, d); check("rhigh", d, 8'h70);
		$display("test software standby done");
		// one-shot converts both channels once
		starts = 0;
		wr(`OFF_ONE_SHOT, 8'hA5);
		cycles(40);
		check("starts", starts[7:0], 8'h02);
		rd(`OFF_LOCAL_VALUE, d); check("local", d, 8'h33);
		rd(`OFF_REMOTE_VALUE, d); check("remote", d, 8'h44);
		$display("test one-shot done");
		// shorted diode gives the minimum code and trips the low limit
		underrange <= 1'b1;
		remote_code <= 8'h55;
		wr(`OFF_ONE_SHOT, 8'h00);
		cycles(40);
		rd(`OFF_REMOTE_VALUE, d); check("remote", d, 8'h80);
		check("alert", {7'h00, alert_oe_n_out}, 8'h00);
		check("line", {7'h00, alert_line}, 8'h00);
		rd(`OFF_STATUS, d); check("rlow", d & 8'h08, 8'h08);
		// host moves the low limit to the minimum code
		wr(`OFF_REMOTE_LOW, 8'h80);
		wr(`OFF_ONE_SHOT, 8'h00);
		cycles(40);
		rd(`OFF_STATUS, d); check("rlow", d & 8'h08, 8'h00);
		cycles(3);
		check("alert", {7'h00, alert_oe_n_out}, 8'h01);
		$display("test underrange done");
		// open diode seen at conversion start
		open_circuit_in <= 1'b1;
		cycles(10);
		wr(`OFF_ONE_SHOT, 8'h00);
		cycles(40);
		check("alert", {7'h00, alert_oe_n_out}, 8'h00);
		check("line", {7'h00, alert_line}, 8'h00);
		rd(`OFF_STATUS, d); check("open", d & 8'h04, 8'h04);
		open_circuit_in <= 1'b0;
		$display("test open diode done");
		// hardware standby blocks one-shot, release resumes conversions
		low_power_request_n_in <= 1'b0;
		cycles(10);
		wr(`OFF_CONFIG, 8'h00);
		cycles(5);
		check("standby", {7'h00, standby_out}, 8'h01);
		starts = 0;
		wr(`OFF_ONE_SHOT, 8'h00);
		cycles(40);
		check("starts", starts[7:0], 8'h00);
		low_power_request_n_in <= 1'b1;
		cycles(60);
		check("standby", {7'h00, standby_out}, 8'h00);
		check("running", {7'h00, starts > 0}, 8'h01);
		// pin low mid-conversion aborts it and leaves both values alone
		do cycles(1); while (adc_start_out !== 1'b1);
		local_code <= 8'h66;
		aborts = 0;
		low_power_request_n_in <= 1'b0;
		cycles(20);
		check("aborts", aborts[7:0], 8'h01);
		rd(`OFF_LOCAL_VALUE, d); check("local", d, 8'h33);
		rd(`OFF_REMOTE_VALUE, d); check("remote", d, 8'h80);
		low_power_request_n_in <= 1'b1;
		$display("test hardware standby done");
		give_verdict();
	end
endmodule // thermal_standby_fault_tb
